// ===== hdl/dsf_decoder.sv
/*
  Serial special-function decoder of a 16-channel DAC.
  Assumes sclk, sync_n, sdi, gpio_in and over_temp are asynchronous pins;
  packet_error_event and chan_rd_data come from logic on clk.
*/
// Notes on behaviour
// - Mode bits 00 mark a word as a special-function command.
// - Bits 21..16 are the function code, bits 15..0 the payload.
// - Control payload bit 2 selects input register B, clear selects A.
// - Control payload bit 1 enables thermal shutdown.
// - Control payload bit 0 requests soft power-down.
// - Control bit 4 reads one while the die is over temperature.
// - Control bit 3 reads one while a packet check error is pending.
// - Codes 000010/000011 load payload bits 13..0 into offset codes.
// - Codes 000110/000111 load payload byte into bank select 0 or 1.
// - Bank select bits pick calibrated register B per channel.
// - Code 001011 writes the payload byte into both bank selects.
// - Monitor payload bit 5 enables the monitor multiplexer.
// - Monitor bit 4 clear routes the channel in bits 3..0.
// - Monitor bits 5 and 4 set route pin chosen by bit 0.
// - GPIO bit 1 set drives bit 0 out; clear makes it input.
// - Code 000101 selects readback address from payload bits 15..7.
// - Payload bits 6..0 of a readback select are ignored.
// - Fixed addresses return control, offset codes and bank selects.
// - Address 100001011 returns the GPIO pin level in bit 0.
// - Selected data shifts out on sdo during the next frame.
// - Reading control clears the packet error flag and pin.
`timescale 1ns/1ps
module dsf_decoder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic over_temp,
  input wire logic packet_error_event,
  output logic pec_n,
  input wire logic gpio_in,
  output logic gpio_out,
  output logic gpio_oe,
  output dsf_pkg::dsf_ctrl_t ctrl,
  output logic [dsf_pkg::OFS_W-1:0] offset_code_0,
  output logic [dsf_pkg::OFS_W-1:0] offset_code_1,
  output logic [15:0] bank_select,
  output dsf_pkg::dsf_mon_t monitor,
  output logic [1:0] chan_rd_kind,
  output logic [3:0] chan_rd_index,
  input wire logic [15:0] chan_rd_data,
  output logic data_word_valid,
  output logic [dsf_pkg::WORD_BITS-1:0] data_word
);

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  logic [2:0] sclk_reg;
  logic [2:0] sync_reg;
  logic [1:0] sdi_reg;
  logic [1:0] temp_reg;
  logic [1:0] gpin_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_reg <= 3'h7;
      sync_reg <= 3'h7;
      sdi_reg <= 2'h0;
      temp_reg <= 2'h0;
      gpin_reg <= 2'h0;
    end else begin
      sclk_reg <= {sclk_reg[1:0], sclk};
      sync_reg <= {sync_reg[1:0], sync_n};
      sdi_reg <= {sdi_reg[0], sdi};
      temp_reg <= {temp_reg[0], over_temp};
      gpin_reg <= {gpin_reg[0], gpio_in};
    end
  end

  logic framed;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_end;
  logic frame_start;

  // Only stage two and three are looked at; stage one feeds stage two.
  assign framed = !sync_reg[1];
  assign sclk_fall = framed && sclk_reg[2] && !sclk_reg[1];
  assign sclk_rise = framed && !sclk_reg[2] && sclk_reg[1];
  assign frame_end = !sync_reg[2] && sync_reg[1];
  assign frame_start = sync_reg[2] && !sync_reg[1];

  // ****************************************************************
  // Word capture
  // ****************************************************************
  logic [dsf_pkg::WORD_BITS-1:0] shift_reg;
  logic [dsf_pkg::CNT_W-1:0] count_reg;
  logic overrun_reg;

  // A frame with more than 24 falling edges is corrupt and is dropped.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= '0;
      count_reg <= '0;
      overrun_reg <= 1'b0;
    end else if (frame_start) begin
      count_reg <= '0;
      overrun_reg <= 1'b0;
    end else if (sclk_fall) begin
      shift_reg <= {shift_reg[dsf_pkg::WORD_BITS-2:0], sdi_reg[1]};
      if (count_reg == dsf_pkg::WORD_COUNT) begin
        overrun_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 5'h01;
      end
    end
  end

  logic word_done;
  logic special;
  logic [5:0] func;
  logic [dsf_pkg::PAY_W-1:0] pay;
  logic [8:0] rb_addr;

  assign word_done = frame_end && !overrun_reg &&
                     count_reg == dsf_pkg::WORD_COUNT;
  assign special = shift_reg[dsf_pkg::MODE_HI:dsf_pkg::MODE_LO] ==
                   dsf_pkg::MODE_SPECIAL;
  assign func = shift_reg[dsf_pkg::FUNC_HI:dsf_pkg::FUNC_LO];
  assign pay = shift_reg[dsf_pkg::PAY_W-1:0];
  assign rb_addr = pay[dsf_pkg::RB_ADDR_HI:dsf_pkg::RB_ADDR_LO];

  logic cmd;
  assign cmd = word_done && special;

  // Channel words are passed on untouched; the data path lives elsewhere.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_word_valid <= 1'b0;
      data_word <= '0;
    end else begin
      data_word_valid <= word_done && !special;
      if (word_done && !special) begin
        data_word <= shift_reg;
      end
    end
  end

  // ****************************************************************
  // Special-function registers
  // ****************************************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= '0;
    end else if (cmd && func == dsf_pkg::FN_CTRL) begin
      // Bits 4 and 3 are status only; whatever the host sends there is
      // dropped rather than trusted.
      ctrl.input_bank_b <= pay[dsf_pkg::CTRL_BANK];
      ctrl.thermal_shutdown_en <= pay[dsf_pkg::CTRL_TSD];
      ctrl.soft_power_down <= pay[dsf_pkg::CTRL_PD];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      offset_code_0 <= dsf_pkg::OFS_RESET;
      offset_code_1 <= dsf_pkg::OFS_RESET;
    end else if (cmd && func == dsf_pkg::FN_OFFSET_DAC_CODE_0) begin
      offset_code_0 <= pay[dsf_pkg::OFS_W-1:0];
    end else if (cmd && func == dsf_pkg::FN_OFFSET_DAC_CODE_1) begin
      offset_code_1 <= pay[dsf_pkg::OFS_W-1:0];
    end
  end

  // Bit n of bank_select steers channel n to calibrated_reg_b.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_select <= {dsf_pkg::BANK_RESET, dsf_pkg::BANK_RESET};
    end else if (cmd) begin
      case (func)
        dsf_pkg::FN_BANK0: begin
          bank_select[7:0] <= pay[dsf_pkg::BANK_W-1:0];
        end
        dsf_pkg::FN_BANK1: begin
          bank_select[15:8] <= pay[dsf_pkg::BANK_W-1:0];
        end
        dsf_pkg::FN_BANK_ALL: begin
          bank_select <= {2{pay[dsf_pkg::BANK_W-1:0]}};
        end
        default: begin
          bank_select <= bank_select;
        end
      endcase
    end
  end

  logic [5:0] mon_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_reg <= dsf_pkg::MON_RESET;
    end else if (cmd && func == dsf_pkg::FN_MONITOR) begin
      mon_reg <= pay[5:0];
    end
  end

  assign monitor.enable = mon_reg[dsf_pkg::MON_EN];
  assign monitor.channel = mon_reg[3:0];
  assign monitor.pin_mode = mon_reg[dsf_pkg::MON_PIN];
  assign monitor.pin_sel = mon_reg[0];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gpio_oe <= 1'b0;
      gpio_out <= 1'b0;
    end else if (cmd && func == dsf_pkg::FN_GPIO) begin
      gpio_oe <= pay[dsf_pkg::GPIO_DIR];
      gpio_out <= pay[dsf_pkg::GPIO_DATA];
    end
  end

  // ****************************************************************
  // Packet error flag
  // ****************************************************************
  logic pec_reg;
  logic rb_sel;
  assign rb_sel = cmd && func == dsf_pkg::FN_READSEL;

  // A new error in the same cycle as the clearing read wins.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pec_reg <= 1'b0;
    end else if (packet_error_event) begin
      pec_reg <= 1'b1;
    end else if (rb_sel && rb_addr == dsf_pkg::RB_CTRL) begin
      pec_reg <= 1'b0;
    end
  end

  assign pec_n = !pec_reg;

  // ****************************************************************
  // Readback
  // ****************************************************************
  logic [4:0] ctrl_word;
  assign ctrl_word = {temp_reg[1], pec_reg, ctrl.input_bank_b,
                      ctrl.thermal_shutdown_en,
                      ctrl.soft_power_down};

  logic [15:0] rb_value;
  logic rb_is_chan;
  logic [5:0] chan_code;
  assign chan_code = rb_addr[5:0];
  assign rb_is_chan = !rb_addr[8] && chan_code >= dsf_pkg::CHAN_BASE &&
                      chan_code <= dsf_pkg::CHAN_LAST;

  // The low payload bits never enter the address compare.
  always_comb begin
    rb_value = 16'h0000;
    case (rb_addr)
      dsf_pkg::RB_CTRL: rb_value = {11'h000, ctrl_word};
      dsf_pkg::RB_OFFSET_DAC_CODE_0: rb_value = {2'h0, offset_code_0};
      dsf_pkg::RB_OFFSET_DAC_CODE_1: rb_value = {2'h0, offset_code_1};
      dsf_pkg::RB_BANK0: rb_value = {8'h00, bank_select[7:0]};
      dsf_pkg::RB_BANK1: rb_value = {8'h00, bank_select[15:8]};
      dsf_pkg::RB_GPIO: rb_value = {15'h0000, gpin_reg[1]};
      default: rb_value = 16'h0000;
    endcase
  end

  // Channel registers live outside; their data is taken one cycle after
  // the select so the external mux sees a stable kind and index.
  logic chan_pend_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_pend_reg <= 1'b0;
      chan_rd_kind <= 2'h0;
      chan_rd_index <= 4'h0;
    end else begin
      chan_pend_reg <= rb_sel && rb_is_chan;
      if (rb_sel && rb_is_chan) begin
        chan_rd_kind <= rb_addr[7:6];
        chan_rd_index <= 4'(chan_code - dsf_pkg::CHAN_BASE);
      end
    end
  end

  logic [dsf_pkg::WORD_BITS-1:0] out_reg;

  // Shift on rising sclk so the host can sample on the falling edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_reg <= '0;
    end else if (rb_sel) begin
      out_reg <= {8'h00, rb_is_chan ? 16'h0000 : rb_value};
    end else if (chan_pend_reg) begin
      out_reg <= {8'h00, chan_rd_data};
    end else if (sclk_rise && sdo_oe) begin
      out_reg <= {out_reg[dsf_pkg::WORD_BITS-2:0], 1'b0};
    end
  end

  // The pin is driven from the select until the next frame has ended;
  // a new select at that same frame end keeps it driven.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sdo_oe <= 1'b0;
    end else if (rb_sel) begin
      sdo_oe <= 1'b1;
    end else if (frame_end) begin
      sdo_oe <= 1'b0;
    end
  end

  assign sdo = out_reg[dsf_pkg::WORD_BITS-1];

endmodule

// ===== pkg/dsf_pkg.sv
/*
  Constants and carrier types of the special-function decoder.
  Assumes a 24-bit serial command word, most significant bit first.
*/
package dsf_pkg;

  localparam int WORD_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_COUNT = 5'h18;
  localparam int MODE_HI = 23;
  localparam int MODE_LO = 22;
  localparam int FUNC_HI = 21;
  localparam int FUNC_LO = 16;
  localparam int PAY_W = 16;
  localparam logic [1:0] MODE_SPECIAL = 2'h0;

  typedef enum logic [5:0] {
    FN_NOP = 6'b000000,
    FN_CTRL = 6'b000001,
    FN_OFFSET_DAC_CODE_0 = 6'b000010,
    FN_OFFSET_DAC_CODE_1 = 6'b000011,
    FN_READSEL = 6'b000101,
    FN_BANK0 = 6'b000110,
    FN_BANK1 = 6'b000111,
    FN_BANK_ALL = 6'b001011,
    FN_MONITOR = 6'b001100,
    FN_GPIO = 6'b001101
  } dsf_func_t;

  localparam int RB_ADDR_HI = 15;
  localparam int RB_ADDR_LO = 7;
  localparam logic [8:0] RB_CTRL = 9'h101;
  localparam logic [8:0] RB_OFFSET_DAC_CODE_0 = 9'h102;
  localparam logic [8:0] RB_OFFSET_DAC_CODE_1 = 9'h103;
  localparam logic [8:0] RB_BANK0 = 9'h106;
  localparam logic [8:0] RB_BANK1 = 9'h107;
  localparam logic [8:0] RB_GPIO = 9'h10b;
  localparam logic [5:0] CHAN_BASE = 6'h08;
  localparam logic [5:0] CHAN_LAST = 6'h17;

  localparam int CTRL_PD = 0;
  localparam int CTRL_TSD = 1;
  localparam int CTRL_BANK = 2;
  localparam int CTRL_PEC = 3;
  localparam int CTRL_TEMP = 4;
  localparam int MON_EN = 5;
  localparam int MON_PIN = 4;
  localparam int GPIO_DIR = 1;
  localparam int GPIO_DATA = 0;
  localparam int OFS_W = 14;
  localparam int BANK_W = 8;

  localparam logic [OFS_W-1:0] OFS_RESET = 14'h0000;
  localparam logic [BANK_W-1:0] BANK_RESET = 8'h00;
  localparam logic [5:0] MON_RESET = 6'h00;

  typedef struct packed {
    logic input_bank_b;
    logic thermal_shutdown_en;
    logic soft_power_down;
  } dsf_ctrl_t;

  typedef struct packed {
    logic enable;
    logic pin_mode;
    logic pin_sel;
    logic [3:0] channel;
  } dsf_mon_t;

endpackage

// ===== bench/dsf_spi_host.sv
/*
  Serial host model that frames 24-bit command words for the decoder.
  Assumes the decoder samples on the falling link clock edge.
*/
`timescale 1ns/1ps
module dsf_spi_host (
  output logic sclk,
  output logic sync_n,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdi = 1'b0;
  end

  // Released data line shows the inverse so a stale bit is never trusted.
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi = w[i];
      #62.5;
      sclk = 1'b0;
      r[i] = sdo;
      #62.5;
      sclk = 1'b1;
    end
    #62.5;
    sync_n = 1'b1;
    sdi = ~sdi;
    #250;
  endtask
endmodule

// ===== bench/dsf_decoder_assertions.sv
/*
  Concurrent checks on the decoder's ports.
  Assumes it is bound into every decoder instance.
*/
`timescale 1ns/1ps
module dsf_decoder_assertions (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic packet_error_event,
  input wire logic pec_n,
  input wire logic gpio_out,
  input wire logic gpio_oe,
  input wire dsf_pkg::dsf_ctrl_t ctrl,
  input wire logic [dsf_pkg::OFS_W-1:0] offset_code_0,
  input wire logic [dsf_pkg::OFS_W-1:0] offset_code_1,
  input wire logic [15:0] bank_select,
  input wire dsf_pkg::dsf_mon_t monitor,
  input wire logic data_word_valid,
  input wire logic [dsf_pkg::WORD_BITS-1:0] data_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_pec_set: assert property (packet_error_event |=> !pec_n)
    else $error("error pin not low after event");
  a_pec_clear: assert property ($rose(pec_n) |-> sdo_oe)
    else $error("error pin cleared without a read");
  a_cfg_hold: assert property ((!sync_n)[*8] |->
    $stable({ctrl, offset_code_0, offset_code_1, bank_select, monitor}))
    else $error("configuration changed inside a frame");
  a_word_mode: assert property (data_word_valid |->
    data_word[23:22] != dsf_pkg::MODE_SPECIAL)
    else $error("special word passed as data");
  a_word_pulse: assert property (data_word_valid |=> !data_word_valid)
    else $error("data word strobe too long");
  a_oe_rise: assert property ($rose(sdo_oe) |-> sync_n && $past(sync_n, 2))
    else $error("output enabled inside a frame");
  a_sdo_hold: assert property ((!sclk && !sync_n)[*6] |-> $stable(sdo))
    else $error("output bit moved while clock low");
  a_gpio_frame: assert property ($changed({gpio_oe, gpio_out}) |->
    sync_n && $past(sync_n, 2))
    else $error("pin setup changed inside a frame");

  c_read: cover property ($rose(sdo_oe));
  c_word: cover property (data_word_valid);
  c_clear: cover property ($rose(pec_n));
endmodule

bind dsf_decoder dsf_decoder_assertions i_chk (.clk, .arst_n, .sclk, .sync_n,
  .sdo, .sdo_oe, .packet_error_event, .pec_n, .gpio_out, .gpio_oe, .ctrl,
  .offset_code_0, .offset_code_1, .bank_select, .monitor, .data_word_valid,
  .data_word);

// ===== bench/testbench.sv
/*
  Self-checking bench for the special-function decoder.
  Assumes the host model in dsf_spi_host and the bound checker.
*/
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic over_temp = 1'b0;
  logic packet_error_event = 1'b0;
  logic gpio_in = 1'b0;
  logic sclk, sync_n, sdi, sdo, sdo_oe, pec_n, gpio_out, gpio_oe;
  logic data_word_valid;
  logic [1:0] chan_rd_kind;
  logic [3:0] chan_rd_index;
  logic [15:0] chan_rd_data, bank_select;
  logic [13:0] offset_code_0, offset_code_1;
  logic [23:0] data_word, dw_seen, r;
  dsf_pkg::dsf_ctrl_t ctrl;
  dsf_pkg::dsf_mon_t monitor;
  int fail_count = 0;
  int n_checks = 0;

  dsf_decoder i_dut (.clk, .arst_n, .sclk, .sync_n, .sdi, .sdo, .sdo_oe,
    .over_temp, .packet_error_event, .pec_n, .gpio_in, .gpio_out, .gpio_oe,
    .ctrl, .offset_code_0, .offset_code_1, .bank_select, .monitor,
    .chan_rd_kind, .chan_rd_index, .chan_rd_data, .data_word_valid,
    .data_word);
  dsf_spi_host i_host (.sclk, .sync_n, .sdi, .sdo);

  // Channel store answers with its own kind and index so routing shows.
  assign chan_rd_data = {chan_rd_kind, 10'h000, chan_rd_index};
  always #2 clk = ~clk;
  always @(posedge clk) if (data_word_valid) dw_seen <= data_word;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] fn, input logic [15:0] pay);
    logic [23:0] d;
    i_host.xfer({2'b00, fn, pay}, d);
  endtask
  task automatic rd(input logic [8:0] a, output logic [23:0] q);
    logic [23:0] d;
    i_host.xfer({2'b00, 6'h05, a, (a == 9'h10b) ? 7'h00 : 7'h7f}, d);
    chk(sdo_oe, 1'b1);
    i_host.xfer(24'h000000, q);
    chk(sdo_oe, 1'b0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic t_regs();
    wr(6'h01, 16'h0005);
    chk(ctrl, 3'h5);
    @(negedge clk) over_temp = 1'b1;
    rd(9'h101, r);
    chk(r, 24'h000015);
    wr(6'h01, 16'h0002);
    chk(ctrl, 3'h2);
    @(negedge clk) packet_error_event = 1'b1;
    @(negedge clk) packet_error_event = 1'b0;
    over_temp = 1'b0;
    chk(pec_n, 1'b0);
    rd(9'h101, r);
    chk(r, 24'h00000a);
    chk(pec_n, 1'b1);
    rd(9'h101, r);
    chk(r, 24'h000002);
    wr(6'h02, 16'hffff);
    wr(6'h03, 16'hc001);
    chk({offset_code_0, offset_code_1}, {14'h3fff, 14'h0001});
    rd(9'h102, r);
    chk(r, 24'h003fff);
    rd(9'h103, r);
    chk(r, 24'h000001);
    $display("register test done");
  endtask

  task automatic t_bank();
    wr(6'h06, 16'hffa5);
    wr(6'h07, 16'h003c);
    chk(bank_select, 16'h3ca5);
    rd(9'h106, r);
    chk(r, 24'h0000a5);
    rd(9'h107, r);
    chk(r, 24'h00003c);
    wr(6'h0b, 16'h00ff);
    chk(bank_select, 16'hffff);
    wr(6'h0b, 16'hff00);
    chk(bank_select, 16'h0000);
    wr(6'h0c, 16'hffba);
    chk(monitor, 7'h6a);
    wr(6'h0c, 16'h002f);
    chk(monitor, 7'h5f);
    $display("bank and monitor test done");
  endtask

  task automatic t_misc();
    logic [55:0] s;
    wr(6'h0d, 16'h0003);
    chk({gpio_oe, gpio_out}, 2'h3);
    wr(6'h0d, 16'h0000);
    chk({gpio_oe, gpio_out}, 2'h0);
    @(negedge clk) gpio_in = 1'b1;
    rd(9'h10b, r);
    chk(r, 24'h000001);
    rd({3'b001, 6'd13}, r);
    chk(r, 24'h004005);
    rd({3'b011, 6'd23}, r);
    chk(r, 24'h00c00f);
    s = {ctrl, offset_code_0, offset_code_1, bank_select, monitor, gpio_oe,
      gpio_out};
    wr(6'h04, 16'hffff);
    wr(6'h0e, 16'hffff);
    chk({ctrl, offset_code_0, offset_code_1, bank_select, monitor, gpio_oe,
      gpio_out}, s);
    rd(9'h104, r);
    chk(r, 24'h000000);
    i_host.xfer(24'hc12345, r);
    chk(dw_seen, 24'hc12345);
    $display("pin, channel and reserved test done");
  endtask

  initial begin
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_regs();
    t_bank();
    t_misc();
    give_verdict();
  end

  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
endmodule
